// File: ics_pkg.sv
// Constants, codes and helper functions for the internal clock source select block.
// Assumes a single 25 MHz reference clock; oscillator rates are modelled as tick rates.
`default_nettype none

package ics_pkg;

	// ----------------------------------------
	// Reference clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
	// Oscillators are modelled at 1/NCO_SCALE of their rate so 32 MHz fits a 25 MHz clock
	localparam int NCO_SCALE = 4;
	localparam int NCO_MODULUS = CLK_KHZ * NCO_SCALE;
	localparam int NCO_ACC_W = $clog2(NCO_MODULUS);
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------
	// Oscillator rates in kHz
	// ----------------------------------------
	localparam logic [15:0] FAST_MAX_KHZ = 16'h7d00;
	localparam logic [15:0] SLOW_KHZ = 16'h001f;

	// ----------------------------------------
	// Source select codes
	// ----------------------------------------
	localparam logic [2:0] SRC_FAST_PLL = 3'h0;
	localparam logic [2:0] SRC_SLOW = 3'h5;
	localparam logic [2:0] SRC_FAST = 3'h6;

	// ----------------------------------------
	// Fast oscillator frequency select codes
	// ----------------------------------------
	localparam logic [3:0] FRQ_1MHZ = 4'h0;
	localparam logic [3:0] FRQ_2MHZ = 4'h1;
	localparam logic [3:0] FRQ_4MHZ = 4'h2;
	localparam logic [3:0] FRQ_8MHZ = 4'h3;
	localparam logic [3:0] FRQ_12MHZ = 4'h4;
	localparam logic [3:0] FRQ_16MHZ = 4'h6;
	localparam logic [3:0] FRQ_32MHZ = 4'h7;

	// ----------------------------------------
	// Reset values and divider range
	// ----------------------------------------
	localparam logic [2:0] RST_SOURCE = SRC_FAST;
	localparam logic [3:0] RST_FREQ = FRQ_1MHZ;
	localparam logic [3:0] RST_DIVIDER = 4'h0;
	localparam logic [3:0] DIV_MAX_CODE = 4'h9;
	localparam int DIV_CNT_W = 9;

	typedef enum logic [1:0] {
		ST_SYNC,
		ST_LOAD,
		ST_RUN,
		ST_SWITCH
	} ics_state_t;

	// Frequency in kHz of a fast oscillator code; zero marks a reserved code
	function automatic logic [15:0] freq_khz(input logic [3:0] code);
		unique case (code)
			FRQ_1MHZ: freq_khz = 16'h03e8;
			FRQ_2MHZ: freq_khz = 16'h07d0;
			FRQ_4MHZ: freq_khz = 16'h0fa0;
			FRQ_8MHZ: freq_khz = 16'h1f40;
			FRQ_12MHZ: freq_khz = 16'h2ee0;
			FRQ_16MHZ: freq_khz = 16'h3e80;
			FRQ_32MHZ: freq_khz = FAST_MAX_KHZ;
			default: freq_khz = 16'h0000;
		endcase
	endfunction

	// Only 8, 12 and 16 MHz may feed the doubler
	function automatic logic pll_input_ok(input logic [3:0] code);
		pll_input_ok = (code == FRQ_8MHZ) || (code == FRQ_12MHZ) || (code == FRQ_16MHZ);
	endfunction

	function automatic logic source_known(input logic [2:0] code);
		source_known = (code == SRC_FAST_PLL) || (code == SRC_SLOW) || (code == SRC_FAST);
	endfunction

endpackage

`default_nettype wire

// File: ics_nco.sv
// Oscillator model: phase accumulator that emits one tick per NCO_SCALE oscillator periods.
// Assumes i_step is a rate in kHz and the reference clock is the package rate.
`default_nettype none

module ics_nco #(
	parameter int ACC_W = ics_pkg::NCO_ACC_W,
	parameter int MODULUS = ics_pkg::NCO_MODULUS
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_run,
	input wire logic [15:0] i_step,
	output logic o_tick
);

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic tick;
	} ics_nco_t;

	ics_nco_t cur;
	ics_nco_t next_cur;
	logic [ACC_W:0] sum;

	always_comb begin
		next_cur = cur;
		sum = {1'b0, cur.acc} + (ACC_W + 1)'(i_step);
		next_cur.tick = 1'b0;
		if (!i_run) begin
			// A stopped oscillator restarts from phase zero
			next_cur.acc = '0;
		end else if (sum >= (ACC_W + 1)'(MODULUS)) begin
			next_cur.acc = ACC_W'(sum - (ACC_W + 1)'(MODULUS));
			next_cur.tick = 1'b1;
		end else begin
			next_cur.acc = ACC_W'(sum);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_tick = cur.tick;

endmodule

`default_nettype wire

// File: ics_div.sv
// Power-of-two post divider on a tick stream, ratios 1:1 to 1:512.
// Assumes i_tick is a one-cycle pulse; codes above the top ratio act as 1:512.
`default_nettype none

module ics_div #(
	parameter int CNT_W = ics_pkg::DIV_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_tick,
	input wire logic i_restart,
	input wire logic [3:0] i_sel,
	output logic o_tick,
	output logic o_level
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic tick;
		logic level;
	} ics_div_t;

	ics_div_t cur;
	ics_div_t next_cur;
	logic [CNT_W-1:0] last;
	logic [3:0] sel;

	always_comb begin
		next_cur = cur;
		sel = (i_sel > ics_pkg::DIV_MAX_CODE) ? ics_pkg::DIV_MAX_CODE : i_sel;
		last = CNT_W'((1 << sel) - 1);
		next_cur.tick = 1'b0;
		if (i_restart) begin
			// Restart on a source change so the first output period is whole
			next_cur.cnt = '0;
			next_cur.level = 1'b0;
		end else if (i_tick) begin
			if (cur.cnt >= last) begin
				next_cur.cnt = '0;
				next_cur.tick = 1'b1;
				next_cur.level = !cur.level;
			end else begin
				next_cur.cnt = cur.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_tick = cur.tick;
	assign o_level = cur.level;

endmodule

`default_nettype wire

// File: ics_top.sv
// Internal clock source select: two internal oscillators, doubler, divider and clock pin.
// Assumes configuration straps are pins (synchronised here) and software ports share I_CLK.
`default_nettype none

module ics_top (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic [2:0] I_RESET_SOURCE_SELECT,
	input wire logic I_CLOCK_OUT_PIN_ENABLE,
	input wire logic I_NEW_SOURCE_WRITE,
	input wire logic [2:0] I_NEW_SOURCE_SELECT,
	input wire logic I_FREQ_WRITE,
	input wire logic [3:0] I_FAST_OSC_FREQ_SELECT,
	input wire logic I_DIVIDER_WRITE,
	input wire logic [3:0] I_SOURCE_DIVIDER,
	output logic [2:0] O_ACTIVE_SOURCE,
	output logic [3:0] O_FAST_OSC_FREQ_SELECT,
	output logic [3:0] O_SOURCE_DIVIDER,
	output logic O_PLL_ENABLE,
	output logic O_PLL_FAULT,
	output logic O_SWITCH_BUSY,
	output logic O_FAST_OSC_RUN,
	output logic O_SLOW_OSC_RUN,
	output logic [15:0] O_SOURCE_FREQ_KHZ,
	output logic O_SYS_TICK,
	output logic O_SYS_CLK,
	output logic O_OSC_CLOCK_OUT_PIN,
	output logic O_OSC_CLOCK_OUT_PIN_OE
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ics_pkg::ics_state_t state;
		logic [2:0] strap_meta;
		logic [2:0] strap_sync;
		logic clkout_meta;
		logic clkout_sync;
		logic [2:0] source;
		logic [2:0] pending;
		logic [3:0] freq_sel;
		logic [3:0] divider;
		logic pll_on;
		logic pll_fault;
		logic restart;
		logic primed;
		logic busy;
		logic fast_run;
		logic slow_run;
		logic [15:0] src_khz;
		logic pin;
		logic pin_oe;
	} ics_top_t;

	ics_top_t cur;
	ics_top_t next_cur;

	logic fast_tick;
	logic slow_tick;
	logic src_tick;
	logic div_tick;
	logic div_level;
	logic [15:0] fast_step;
	logic pll_doubling;
	logic [15:0] fast_khz;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Tick of the oscillator behind a source code
	function automatic logic pick_tick(input logic [2:0] code, input logic slow,
		input logic fast);
		pick_tick = (code == ics_pkg::SRC_SLOW) ? slow : fast;
	endfunction

	// An oscillator is wanted while it drives the clock or a pending switch waits on it
	function automatic logic osc_wanted(input ics_top_t st, input logic slow);
		osc_wanted = ((st.source == ics_pkg::SRC_SLOW) == slow) ||
			(st.state == ics_pkg::ST_SWITCH && ((st.pending == ics_pkg::SRC_SLOW) == slow));
	endfunction

	// ----------------------------------------
	// Oscillators
	// ----------------------------------------
	// Doubler only acts on a legal input; an illegal one passes undoubled and is flagged
	assign pll_doubling = cur.pll_on && ics_pkg::pll_input_ok(cur.freq_sel);
	assign fast_khz = ics_pkg::freq_khz(cur.freq_sel);
	// Doubling is a one-bit shift; every legal doubler input fits in 15 bits
	assign fast_step = pll_doubling ? {fast_khz[14:0], 1'b0} : fast_khz;

	// Fast oscillator rate follows the select code and the doubler
	ics_nco u_fast_osc (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_run(cur.fast_run),
		.i_step(fast_step),
		.o_tick(fast_tick)
	);

	// Slow oscillator rate is fixed; only its run enable changes
	ics_nco u_slow_osc (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_run(cur.slow_run),
		.i_step(ics_pkg::SLOW_KHZ),
		.o_tick(slow_tick)
	);

	// ----------------------------------------
	// Source mux and divider
	// ----------------------------------------
	assign src_tick = pick_tick(cur.source, slow_tick, fast_tick);

	// Restart pulse lines the divider up with the first tick of a new source
	ics_div u_divider (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_tick(src_tick),
		.i_restart(cur.restart),
		.i_sel(cur.divider),
		.o_tick(div_tick),
		.o_level(div_level)
	);

	// ----------------------------------------
	// Control
	// ----------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.restart = 1'b0;

		// ----------------------------------------
		// Synchronisers
		// ----------------------------------------
		// Straps are pins: two flops before anything reads them
		next_cur.strap_meta = I_RESET_SOURCE_SELECT;
		next_cur.strap_sync = cur.strap_meta;
		next_cur.clkout_meta = I_CLOCK_OUT_PIN_ENABLE;
		next_cur.clkout_sync = cur.clkout_meta;

		// ----------------------------------------
		// Start-up and source switching
		// ----------------------------------------
		unique case (cur.state)
			ics_pkg::ST_SYNC: begin
				// Wait two edges so the strap has crossed both synchroniser flops
				next_cur.primed = 1'b1;
				if (cur.primed) begin
					next_cur.state = ics_pkg::ST_LOAD;
				end
			end
			ics_pkg::ST_LOAD: begin
				// Strap is caught once after reset release, when the synchroniser is full
				next_cur.state = ics_pkg::ST_RUN;
				next_cur.restart = 1'b1;
				// Strap 000 starts the doubler on a 16 MHz input for 32 MHz
				if (cur.strap_sync == ics_pkg::SRC_FAST_PLL) begin
					next_cur.source = ics_pkg::SRC_FAST_PLL;
					next_cur.freq_sel = ics_pkg::FRQ_16MHZ;
					next_cur.pll_on = 1'b1;
				end else if (cur.strap_sync == ics_pkg::SRC_SLOW) begin
					next_cur.source = ics_pkg::SRC_SLOW;
					next_cur.pll_on = 1'b0;
				end else begin
					// Unlisted strap codes fall back to the 1 MHz start
					next_cur.source = ics_pkg::SRC_FAST;
					next_cur.freq_sel = ics_pkg::FRQ_1MHZ;
					next_cur.pll_on = 1'b0;
				end
			end
			ics_pkg::ST_RUN: begin
				// Unknown codes and writes during a switch are dropped without notice
				if (I_NEW_SOURCE_WRITE && ics_pkg::source_known(I_NEW_SOURCE_SELECT)) begin
					next_cur.pending = I_NEW_SOURCE_SELECT;
					next_cur.state = ics_pkg::ST_SWITCH;
				end
			end
			ics_pkg::ST_SWITCH: begin
				// Hand over only on a tick of the new source, so no runt period reaches the divider
				if (pick_tick(cur.pending, slow_tick, fast_tick)) begin
					next_cur.source = cur.pending;
					next_cur.pll_on = (cur.pending == ics_pkg::SRC_FAST_PLL);
					next_cur.restart = 1'b1;
					next_cur.state = ics_pkg::ST_RUN;
				end
			end
		endcase

		// ----------------------------------------
		// Software writes
		// ----------------------------------------
		// A frequency change reaches the oscillator on the next edge, without a switch
		// Software frequency and divider writes in ST_RUN or ST_SWITCH take effect at once; reserved frequency codes are ignored, every divider code is kept
		if (cur.state == ics_pkg::ST_RUN || cur.state == ics_pkg::ST_SWITCH) begin
			if (I_FREQ_WRITE && ics_pkg::freq_khz(I_FAST_OSC_FREQ_SELECT) != 16'h0000) begin
				next_cur.freq_sel = I_FAST_OSC_FREQ_SELECT;
			end
			if (I_DIVIDER_WRITE) begin
				next_cur.divider = I_SOURCE_DIVIDER;
			end
		end

		// ----------------------------------------
		// Oscillator enables and status
		// ----------------------------------------
		// Each oscillator runs while it drives the clock or is about to
		next_cur.fast_run = osc_wanted(next_cur, 1'b0);
		next_cur.slow_run = osc_wanted(next_cur, 1'b1);
		// Busy is registered so the status pin comes straight from a flop
		next_cur.busy = (next_cur.state == ics_pkg::ST_SWITCH);

		// ----------------------------------------
		// Doubler fault
		// ----------------------------------------
		// Software must pick a doubler input; otherwise the fault stays up
		next_cur.pll_fault = next_cur.pll_on && !ics_pkg::pll_input_ok(next_cur.freq_sel);

		// ----------------------------------------
		// Source rate
		// ----------------------------------------
		// Rate lags the source by one cycle; software polls it, so that is harmless
		if (cur.source == ics_pkg::SRC_SLOW) begin
			next_cur.src_khz = ics_pkg::SLOW_KHZ;
		end else begin
			next_cur.src_khz = fast_step;
		end

		// ----------------------------------------
		// Clock pin
		// ----------------------------------------
		// Pin carries the divided clock only when the config bit asks for it
		next_cur.pin_oe = cur.clkout_sync;
		next_cur.pin = cur.clkout_sync & div_level;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// One register stage for the whole state; reset values are constants only
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			cur <= '{
				state: ics_pkg::ST_SYNC,
				strap_meta: 3'h0,
				strap_sync: 3'h0,
				clkout_meta: 1'b0,
				clkout_sync: 1'b0,
				source: ics_pkg::RST_SOURCE,
				pending: ics_pkg::RST_SOURCE,
				freq_sel: ics_pkg::RST_FREQ,
				divider: ics_pkg::RST_DIVIDER,
				pll_on: 1'b0,
				pll_fault: 1'b0,
				restart: 1'b0,
				primed: 1'b0,
				busy: 1'b0,
				fast_run: 1'b1,
				slow_run: 1'b0,
				src_khz: 16'h0000,
				pin: 1'b0,
				pin_oe: 1'b0
			};
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a register here or in a submodule
	assign O_ACTIVE_SOURCE = cur.source;
	assign O_FAST_OSC_FREQ_SELECT = cur.freq_sel;
	assign O_SOURCE_DIVIDER = cur.divider;
	assign O_PLL_ENABLE = cur.pll_on;
	assign O_PLL_FAULT = cur.pll_fault;
	assign O_SWITCH_BUSY = cur.busy;
	assign O_FAST_OSC_RUN = cur.fast_run;
	assign O_SLOW_OSC_RUN = cur.slow_run;
	assign O_SOURCE_FREQ_KHZ = cur.src_khz;
	assign O_SYS_TICK = div_tick;
	assign O_SYS_CLK = div_level;
	assign O_OSC_CLOCK_OUT_PIN = cur.pin;
	assign O_OSC_CLOCK_OUT_PIN_OE = cur.pin_oe;

endmodule

`default_nettype wire

// File: ics_sva.sv
// Concurrent checks for the clock source select top, bound to its ports.
// Assumes one clock domain with an asynchronous active-low reset.
`default_nettype none
module ics_sva (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_CLOCK_OUT_PIN_ENABLE,
	input wire logic I_NEW_SOURCE_WRITE,
	input wire logic [2:0] I_NEW_SOURCE_SELECT,
	input wire logic I_FREQ_WRITE,
	input wire logic [3:0] I_FAST_OSC_FREQ_SELECT,
	input wire logic I_DIVIDER_WRITE,
	input wire logic [3:0] I_SOURCE_DIVIDER,
	input wire logic [2:0] O_ACTIVE_SOURCE,
	input wire logic [3:0] O_FAST_OSC_FREQ_SELECT,
	input wire logic [3:0] O_SOURCE_DIVIDER,
	input wire logic O_PLL_ENABLE,
	input wire logic O_PLL_FAULT,
	input wire logic O_SWITCH_BUSY,
	input wire logic O_SYS_CLK,
	input wire logic O_OSC_CLOCK_OUT_PIN,
	input wire logic O_OSC_CLOCK_OUT_PIN_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// Properties
	// ----------------
	// A slow switch outlasts any delay range, so busy time is counted
	logic [1:0] up;
	logic [11:0] busy_n;
	logic f_ok;
	assign f_ok = I_FAST_OSC_FREQ_SELECT inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			up <= 2'h0;
			busy_n <= 12'h000;
		end else begin
			up <= (up == 2'h3) ? up : up + 2'h1;
			busy_n <= O_SWITCH_BUSY ? busy_n + 12'h001 : 12'h000;
		end
	end
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	property p_busy_start;
		I_NEW_SOURCE_WRITE && up == 2'h3 && !O_SWITCH_BUSY
		&& I_NEW_SOURCE_SELECT != O_ACTIVE_SOURCE
		&& I_NEW_SOURCE_SELECT inside {3'h0, 3'h5, 3'h6} |=> O_SWITCH_BUSY;
	endproperty
	property p_busy_bound;
		busy_n < 12'hfa0;
	endproperty
	property p_src_set;
		O_ACTIVE_SOURCE inside {3'h0, 3'h5, 3'h6};
	endproperty
	property p_pll_src;
		!O_SWITCH_BUSY && $stable(O_ACTIVE_SOURCE) |-> O_PLL_ENABLE == (O_ACTIVE_SOURCE == 3'h0);
	endproperty
	property p_fault;
		$stable(O_FAST_OSC_FREQ_SELECT) && $stable(O_PLL_ENABLE) |-> O_PLL_FAULT ==
		(O_PLL_ENABLE && !(O_FAST_OSC_FREQ_SELECT inside {4'h3, 4'h4, 4'h6}));
	endproperty
	property p_freq_wr;
		I_FREQ_WRITE && up == 2'h3 && f_ok |=> O_FAST_OSC_FREQ_SELECT == $past(I_FAST_OSC_FREQ_SELECT);
	endproperty
	property p_freq_rsv;
		I_FREQ_WRITE && !f_ok |=> $stable(O_FAST_OSC_FREQ_SELECT);
	endproperty
	property p_div_wr;
		I_DIVIDER_WRITE && up == 2'h3 |=> O_SOURCE_DIVIDER == $past(I_SOURCE_DIVIDER);
	endproperty
	property p_pin;
		O_OSC_CLOCK_OUT_PIN_OE && $past(O_OSC_CLOCK_OUT_PIN_OE) |-> O_OSC_CLOCK_OUT_PIN == $past(O_SYS_CLK);
	endproperty
	property p_oe_rise;
		$rose(I_CLOCK_OUT_PIN_ENABLE) |-> ##[1:4] O_OSC_CLOCK_OUT_PIN_OE;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("switch did not start");
	a_busy_bound: assert property (p_busy_bound) else $error("switch took too long");
	a_src_set: assert property (p_src_set) else $error("unknown active source");
	a_pll_src: assert property (p_pll_src) else $error("doubler state wrong");
	a_fault: assert property (p_fault) else $error("doubler fault wrong");
	a_freq_wr: assert property (p_freq_wr) else $error("frequency not taken");
	a_freq_rsv: assert property (p_freq_rsv) else $error("reserved code taken");
	a_div_wr: assert property (p_div_wr) else $error("divider not taken");
	a_pin: assert property (p_pin) else $error("pin not following clock");
	a_oe_rise: assert property (p_oe_rise) else $error("pin not driven");
	c_fault: cover property (O_PLL_FAULT);
	c_busy: cover property ($rose(O_SWITCH_BUSY));
	c_oe: cover property ($rose(O_OSC_CLOCK_OUT_PIN_OE));
endmodule
bind ics_top ics_sva u_sva (.I_CLK, .I_RST_B, .I_CLOCK_OUT_PIN_ENABLE, .I_NEW_SOURCE_WRITE,
	.I_NEW_SOURCE_SELECT, .I_FREQ_WRITE, .I_FAST_OSC_FREQ_SELECT, .I_DIVIDER_WRITE,
	.I_SOURCE_DIVIDER, .O_ACTIVE_SOURCE, .O_FAST_OSC_FREQ_SELECT, .O_SOURCE_DIVIDER,
	.O_PLL_ENABLE, .O_PLL_FAULT, .O_SWITCH_BUSY, .O_SYS_CLK, .O_OSC_CLOCK_OUT_PIN,
	.O_OSC_CLOCK_OUT_PIN_OE);
`default_nettype wire

// File: tb.sv
// Self-checking bench for the clock source select top.
// Assumes the checker is bound in; the bench drives all ports itself.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CLK = 1'b0;
	logic I_RST_B = 1'b0;
	logic [2:0] I_RESET_SOURCE_SELECT = 3'h6;
	logic I_CLOCK_OUT_PIN_ENABLE = 1'b0;
	logic I_NEW_SOURCE_WRITE = 1'b0;
	logic [2:0] I_NEW_SOURCE_SELECT = 3'h0;
	logic I_FREQ_WRITE = 1'b0;
	logic [3:0] I_FAST_OSC_FREQ_SELECT = 4'h0;
	logic I_DIVIDER_WRITE = 1'b0;
	logic [3:0] I_SOURCE_DIVIDER = 4'h0;
	logic [2:0] O_ACTIVE_SOURCE;
	logic [3:0] O_FAST_OSC_FREQ_SELECT, O_SOURCE_DIVIDER;
	logic O_PLL_ENABLE, O_PLL_FAULT, O_SWITCH_BUSY, O_FAST_OSC_RUN, O_SLOW_OSC_RUN;
	logic [15:0] O_SOURCE_FREQ_KHZ;
	logic O_SYS_TICK, O_SYS_CLK, O_OSC_CLOCK_OUT_PIN, O_OSC_CLOCK_OUT_PIN_OE;
	logic [31:0] obs;
	logic [31:0] notes[$];
	logic [7:0] lfsr = 8'h2b;
	int failures = 0;
	int comparisons = 0;
	assign obs = {O_ACTIVE_SOURCE, O_FAST_OSC_FREQ_SELECT, O_SOURCE_DIVIDER, O_PLL_ENABLE,
		O_PLL_FAULT, O_SWITCH_BUSY, O_FAST_OSC_RUN, O_SLOW_OSC_RUN, O_SOURCE_FREQ_KHZ};
	ics_top dut (.I_CLK, .I_RST_B, .I_RESET_SOURCE_SELECT, .I_CLOCK_OUT_PIN_ENABLE,
		.I_NEW_SOURCE_WRITE, .I_NEW_SOURCE_SELECT, .I_FREQ_WRITE, .I_FAST_OSC_FREQ_SELECT,
		.I_DIVIDER_WRITE, .I_SOURCE_DIVIDER, .O_ACTIVE_SOURCE, .O_FAST_OSC_FREQ_SELECT,
		.O_SOURCE_DIVIDER, .O_PLL_ENABLE, .O_PLL_FAULT, .O_SWITCH_BUSY, .O_FAST_OSC_RUN,
		.O_SLOW_OSC_RUN, .O_SOURCE_FREQ_KHZ, .O_SYS_TICK, .O_SYS_CLK, .O_OSC_CLOCK_OUT_PIN,
		.O_OSC_CLOCK_OUT_PIN_OE);
	// ----------------
	// Helpers
	// ----------------
	initial begin
		forever #20 I_CLK = ~I_CLK;
	end
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Zero marks a reserved code
	function automatic logic [15:0] khz(input logic [3:0] c);
		case (c)
			4'h0: return 16'h03e8;
			4'h1: return 16'h07d0;
			4'h2: return 16'h0fa0;
			4'h3: return 16'h1f40;
			4'h4: return 16'h2ee0;
			4'h6: return 16'h3e80;
			4'h7: return 16'h7d00;
			default: return 16'h0000;
		endcase
	endfunction
	function automatic logic [31:0] ex(input logic [2:0] s, input logic [3:0] f, input logic [3:0] d,
		input logic [2:0] pfb, input logic [1:0] run, input logic [15:0] k);
		return {s, f, d, pfb, run, k};
	endfunction
	task automatic complete_run;
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	always @(negedge I_CLK) begin
		if (notes.size() > 0)
			chk(obs, notes.pop_front());
	end
	task automatic step(input int n);
		repeat (n) @(posedge I_CLK);
		#1;
	endtask
	task automatic note(input logic [31:0] e);
		notes.push_back(e);
		step(1);
	endtask
	// The gap after each pulse keeps back-to-back writes apart
	task automatic wr(input logic [2:0] we, input logic [3:0] v);
		{I_NEW_SOURCE_WRITE, I_FREQ_WRITE, I_DIVIDER_WRITE} = we;
		I_NEW_SOURCE_SELECT = v[2:0];
		I_FAST_OSC_FREQ_SELECT = v;
		I_SOURCE_DIVIDER = v;
		step(1);
		{I_NEW_SOURCE_WRITE, I_FREQ_WRITE, I_DIVIDER_WRITE} = 3'h0;
		step(1);
	endtask
	task automatic do_reset(input logic [2:0] s);
		I_RST_B = 1'b0;
		I_RESET_SOURCE_SELECT = s;
		step(3);
		I_RST_B = 1'b1;
		step(4);
	endtask
	task automatic wait_idle;
		int t;
		t = 0;
		while (O_SWITCH_BUSY !== 1'b0 && t < 5000) begin
			step(1);
			t++;
		end
		if (t >= 5000)
			failures++;
		step(2);
	endtask
	task automatic period(output logic [31:0] n);
		int t;
		t = 0;
		while (O_SYS_TICK !== 1'b1 && t < 3000) begin
			step(1);
			t++;
		end
		step(1);
		n = 32'h1;
		while (O_SYS_TICK !== 1'b1 && n < 32'hbb8) begin
			step(1);
			n++;
		end
	endtask
	// ----------------
	// Stimulus
	// ----------------
	initial begin
		repeat (20000) @(posedge I_CLK);
		failures++;
		complete_run;
	end
	initial begin
		logic [3:0] f;
		logic [3:0] c;
		logic [31:0] n;
		do_reset(3'h6);
		note(ex(3'h6, 4'h0, 4'h0, 3'h0, 2'h2, 16'h03e8));
		f = 4'h0;
		lfsr = nx(lfsr);
		for (int i = 0; i < 16; i++) begin
			c = i[3:0] ^ lfsr[3:0];
			wr(3'h3, c);
			if (khz(c) != 16'h0000)
				f = c;
			step(1);
			note(ex(3'h6, f, c, 3'h0, 2'h2, khz(f)));
		end
		wr(3'h3, 4'h0);
		period(n);
		chk(n, 32'h64);
		wr(3'h1, 4'h2);
		period(n);
		chk(n, 32'h190);
		I_CLOCK_OUT_PIN_ENABLE = 1'b1;
		step(5);
		chk({31'h0, O_OSC_CLOCK_OUT_PIN_OE}, 32'h1);
		period(n);
		chk(n, 32'h190);
		chk({31'h0, O_OSC_CLOCK_OUT_PIN ^ O_SYS_CLK}, 32'h1);
		step(1);
		chk({31'h0, O_OSC_CLOCK_OUT_PIN ^ O_SYS_CLK}, 32'h0);
		wr(3'h4, 4'h5);
		note(ex(3'h6, 4'h0, 4'h2, 3'h1, 2'h3, 16'h03e8));
		wr(3'h4, 4'h0);
		wait_idle;
		note(ex(3'h5, 4'h0, 4'h2, 3'h0, 2'h1, 16'h001f));
		wr(3'h2, 4'h3);
		wr(3'h4, 4'h0);
		wait_idle;
		note(ex(3'h0, 4'h3, 4'h2, 3'h4, 2'h2, 16'h3e80));
		wr(3'h1, 4'h4);
		period(n);
		chk(n, 32'h64);
		wr(3'h2, 4'h2);
		step(1);
		note(ex(3'h0, 4'h2, 4'h4, 3'h6, 2'h2, 16'h0fa0));
		wr(3'h2, 4'h6);
		step(1);
		note(ex(3'h0, 4'h6, 4'h4, 3'h4, 2'h2, 16'h7d00));
		I_CLOCK_OUT_PIN_ENABLE = 1'b0;
		step(5);
		chk({31'h0, O_OSC_CLOCK_OUT_PIN_OE}, 32'h0);
		do_reset(3'h5);
		note(ex(3'h5, 4'h0, 4'h0, 3'h0, 2'h1, 16'h001f));
		wr(3'h4, 4'h3);
		note(ex(3'h5, 4'h0, 4'h0, 3'h0, 2'h1, 16'h001f));
		do_reset(3'h0);
		note(ex(3'h0, 4'h6, 4'h0, 3'h4, 2'h2, 16'h7d00));
		complete_run;
	end
endmodule
`default_nettype wire
